// [spq_core.v]
// spq_core.v: software-facing side of a serial peripheral unit: fifo
// ports, clock source selection, config registers and a slave shifter.
// assumes an axi4-lite master on aclk; serial pins come from another domain.
// assumes the peer holds select high for some aclk cycles between frames
// and keeps each sck phase longer than three aclk cycles.
// Summary of operation
// [R1] reading rx buffer with data returns oldest byte and pops it
// [R2] reading empty rx buffer returns zero and sets rx read error flag
// [R3] writing tx buffer when not full appends byte, advances write pointer
// [R4] writing full tx buffer is discarded and sets tx write error flag
// [R5] clock select codes 0-4 pick oscillators, reference clock, timer zero
// [R6] codes 5-7 pick three eight-bit timers, code 8 measure timer match
// [R7] codes 9 to 15 are reserved and select no clock
// [R8] interrupt flags at bits 7,6,5,4,2,1 with matching enable bits
// [R9] transfer counter is 11 bits, split over low and high registers
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`include "spq_map.vh"
module spq_core (
	input wire aclk, // system clock, 40 mhz
	input wire aresetn, // synchronous reset, active low
	input wire [7:0] s_axi_awaddr, // write address
	input wire s_axi_awvalid, // write address valid
	output wire s_axi_awready, // write address ready
	input wire [31:0] s_axi_wdata, // write data
	input wire [3:0] s_axi_wstrb, // write byte strobes
	input wire s_axi_wvalid, // write data valid
	output wire s_axi_wready, // write data ready
	output reg [1:0] s_axi_bresp, // write response
	output reg s_axi_bvalid, // write response valid
	input wire s_axi_bready, // write response ready
	input wire [7:0] s_axi_araddr, // read address
	input wire s_axi_arvalid, // read address valid
	output wire s_axi_arready, // read address ready
	output reg [31:0] s_axi_rdata, // read data
	output reg [1:0] s_axi_rresp, // read response
	output reg s_axi_rvalid, // read data valid
	input wire s_axi_rready, // read data ready
	input wire [8:0] clk_sources, // candidate clock source levels
	input wire sck_in, // serial clock from the peer
	input wire sdi_in, // serial data from the peer
	input wire ss_n_in, // slave select from the peer, active low
	output reg sdo_out, // serial data to the peer
	output wire spi_clk_sel, // selected clock source level
	output wire irq // level interrupt
);
	// queue depth is fixed; no occupancy count is kept, only pointers
	localparam AW = `SPQ_FIFO_AW;
	localparam DEPTH = 1 << AW;

	// fifo storage and pointers; one spare pointer bit tells full from empty
	reg [7:0] rxq [0:DEPTH-1];
	reg [7:0] txq [0:DEPTH-1];
	reg [AW:0] rx_wp_q, rx_rp_q, tx_wp_q, tx_rp_q;
	wire rx_empty = (rx_wp_q == rx_rp_q);
	wire rx_full = (rx_wp_q[AW] != rx_rp_q[AW]) &&
		(rx_wp_q[AW-1:0] == rx_rp_q[AW-1:0]);
	wire tx_empty = (tx_wp_q == tx_rp_q);
	wire tx_full = (tx_wp_q[AW] != tx_rp_q[AW]) &&
		(tx_wp_q[AW-1:0] == tx_rp_q[AW-1:0]);

	// registers
	reg [7:0] intf_q, inte_q, twidth_q, baud_q, con0_q, con1_q, con2_q;
	reg [7:0] clk_q;
	reg [10:0] transfer_counter_q;
	reg tx_write_error_flag_q, rx_read_error_flag_q;
	reg [`SPQ_EV_N-1:0] ev_stat_q, ev_en_q;

	// axi write side: address and data held until both present
	reg aw_have_q, w_have_q;
	reg [7:0] aw_q;
	reg [31:0] wd_q;
	reg [3:0] ws_q;
	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready = !w_have_q && !s_axi_bvalid;
	// an item taken early is parked until its partner arrives
	wire aw_ok = aw_have_q | s_axi_awvalid;
	wire w_ok = w_have_q | s_axi_wvalid;
	wire [7:0] wa = aw_have_q ? aw_q : s_axi_awaddr;
	wire [31:0] wd = w_have_q ? wd_q : s_axi_wdata;
	wire [3:0] ws = w_have_q ? ws_q : s_axi_wstrb;
	wire wr_do = aw_ok && w_ok && !s_axi_bvalid;
	// only byte lane zero carries register data
	wire wr_b0 = wr_do && ws[0];
	wire [7:0] wb = wd[7:0];

	// axi read side: one cycle to answer
	assign s_axi_arready = !s_axi_rvalid;
	wire rd_do = s_axi_arvalid && !s_axi_rvalid;
	wire rd_rxb = rd_do && (s_axi_araddr == `SPQ_OFF_RXB);

	// decoded strobes for registers with side effects
	wire w_txb = wr_b0 && (wa == `SPQ_OFF_TXB);
	wire w_stat = wr_b0 && (wa == `SPQ_OFF_STATUS);
	wire clrbf = w_stat && wb[`SPQ_ST_CLRBF];
	wire w_evclr = wr_b0 && (wa == `SPQ_OFF_EVT_CLR);
	// side effects of the two buffer ports on their queues
	wire pop_rx = rd_rxb && !rx_empty; // [R1]
	wire rd_err = rd_rxb && rx_empty; // [R2]
	wire push_tx = w_txb && !tx_full; // [R3]
	wire wr_err = w_txb && tx_full; // [R4]

	// clock source mux; reserved codes select nothing
	reg sel_lvl;
	always @* begin
		case (clk_q[3:0])
		`SPQ_CS_SYS: sel_lvl = clk_sources[0]; // [R5]
		`SPQ_CS_FAST: sel_lvl = clk_sources[1]; // [R5]
		`SPQ_CS_MED: sel_lvl = clk_sources[2]; // [R5]
		`SPQ_CS_REF: sel_lvl = clk_sources[3]; // [R5]
		`SPQ_CS_TIMER_ZERO_OVERFLOW: sel_lvl = clk_sources[4]; // [R5]
		`SPQ_CS_TMRA: sel_lvl = clk_sources[5]; // [R6]
		`SPQ_CS_TMRB: sel_lvl = clk_sources[6]; // [R6]
		`SPQ_CS_TMRC: sel_lvl = clk_sources[7]; // [R6]
		`SPQ_CS_SMT: sel_lvl = clk_sources[8]; // [R6]
		default: sel_lvl = 1'b0; // [R7]
		endcase
	end
	// a level mux only; nothing in this block is clocked by the pick
	assign spi_clk_sel = sel_lvl;

	// pin synchronisers, two flops each before any logic looks
	// reset to the idle pin levels (select high, clock low): no false edge
	reg [2:0] pin_m_q, pin_s_q;
	reg sck_prev_q;
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_m_q <= 3'h4;
			pin_s_q <= 3'h4;
			sck_prev_q <= 1'b0;
		end else begin
			pin_m_q <= {ss_n_in, sdi_in, sck_in};
			pin_s_q <= pin_m_q;
			sck_prev_q <= pin_s_q[0];
		end
	end
	// synchronised levels; edges compare with the previous sample
	wire sck_s = pin_s_q[0];
	wire sdi_s = pin_s_q[1];
	wire ss_act = !pin_s_q[2];
	wire sck_rise = sck_s && !sck_prev_q;
	wire sck_fall = !sck_s && sck_prev_q;
	wire spi_on = con0_q[`SPQ_C0_EN];

	// slave shifter, mode 0: sample on rise, shift out on fall. only the
	// unit's slave role is modelled; master timing lives elsewhere.
	reg [7:0] sh_in_q, sh_out_q;
	reg [2:0] bit_q;
	reg ss_prev_q;
	reg armed_q; // next byte already in the shifter
	// a byte completes on the eighth sampled rise
	wire byte_done = spi_on && ss_act && sck_rise && (bit_q == 3'h7);
	wire push_rx = byte_done && con2_q[`SPQ_C2_RXR] && !rx_full;
	wire rx_ovf = byte_done && con2_q[`SPQ_C2_RXR] && rx_full;
	wire load_tx = spi_on && ss_act && ((!ss_prev_q && !armed_q) ||
		(sck_fall && bit_q == 3'h0));
	wire pop_tx = load_tx && !tx_empty;
	wire tx_unf = load_tx && tx_empty && con2_q[`SPQ_C2_TXR];
	// select edges and the counter end feed the interrupt flags
	wire sel_start = spi_on && ss_act && !ss_prev_q;
	wire sel_end = spi_on && !ss_act && ss_prev_q;
	wire tc_zero = byte_done && (transfer_counter_q == 11'h001);
	always @(posedge aclk) begin
		if (!aresetn) begin
			sh_in_q <= 8'h00;
			sh_out_q <= 8'h00;
			bit_q <= 3'h0;
			ss_prev_q <= 1'b0;
			armed_q <= 1'b0;
			sdo_out <= 1'b0;
		end else begin
			ss_prev_q <= ss_act;
			if (!ss_act || !spi_on) begin
				bit_q <= 3'h0;
			end else if (sck_rise) begin
				sh_in_q <= {sh_in_q[6:0], sdi_s};
				bit_q <= bit_q + 3'h1;
			end
			if (load_tx) begin
				sh_out_q <= pop_tx ? txq[tx_rp_q[AW-1:0]] : 8'h00;
				sdo_out <= pop_tx ? txq[tx_rp_q[AW-1:0]][7] : 1'b0;
			end else if (spi_on && ss_act && sck_fall) begin
				sh_out_q <= {sh_out_q[6:0], 1'b0};
				sdo_out <= sh_out_q[6];
			end
			// a byte loaded as the last frame ended waits for the next
			// select, so that select must not pop a second byte
			if (!spi_on || clrbf)
				armed_q <= 1'b0;
			else if (load_tx)
				armed_q <= pop_tx;
			else if (ss_act && sck_rise && bit_q == 3'h0)
				armed_q <= 1'b0;
		end
	end

	// fifo pointers; clear-buffer empties both queues
	always @(posedge aclk) begin
		if (!aresetn || clrbf) begin
			rx_wp_q <= {(AW+1){1'b0}};
			rx_rp_q <= {(AW+1){1'b0}};
			tx_wp_q <= {(AW+1){1'b0}};
			tx_rp_q <= {(AW+1){1'b0}};
		end else begin
			if (push_rx) begin
				rxq[rx_wp_q[AW-1:0]] <= {sh_in_q[6:0], sdi_s};
				rx_wp_q <= rx_wp_q + 1'b1;
			end
			if (pop_rx)
				rx_rp_q <= rx_rp_q + 1'b1; // [R1]
			// a full queue is never written: data and pointer stay [R4]
			if (push_tx) begin
				txq[tx_wp_q[AW-1:0]] <= wb; // [R3]
				tx_wp_q <= tx_wp_q + 1'b1; // [R3]
			end
			if (pop_tx)
				tx_rp_q <= tx_rp_q + 1'b1;
		end
	end

	// software registers; hardware sets win over clears in the same cycle
	// hardware sets, or'ed in after any software write
	wire [7:0] intf_set = {byte_done & tx_empty, tc_zero, sel_start,
		sel_end, 1'b0, rx_ovf, tx_unf, 1'b0};
	wire [`SPQ_EV_N-1:0] ev_set = {push_rx, wr_err, rd_err};
	always @(posedge aclk) begin
		if (!aresetn) begin
			intf_q <= 8'h00;
			inte_q <= 8'h00;
			twidth_q <= 8'h00;
			baud_q <= 8'h00;
			con0_q <= 8'h00;
			con1_q <= `SPQ_CON1_RST;
			con2_q <= 8'h00;
			clk_q <= 8'h00;
			transfer_counter_q <= 11'h000;
			tx_write_error_flag_q <= 1'b0;
			rx_read_error_flag_q <= 1'b0;
			ev_stat_q <= {`SPQ_EV_N{1'b0}};
			ev_en_q <= {`SPQ_EV_N{1'b0}};
		end else begin
			if (wr_b0) begin
				case (wa)
				`SPQ_OFF_INTF: intf_q <= wb & `SPQ_INT_MASK; // [R8]
				`SPQ_OFF_INTE: inte_q <= wb & `SPQ_INT_MASK; // [R8]
				`SPQ_OFF_TCNTH: transfer_counter_q[10:8] <= wb[2:0]; // [R9]
				`SPQ_OFF_TCNTL: transfer_counter_q[7:0] <= wb; // [R9]
				`SPQ_OFF_TWIDTH: twidth_q <= wb & `SPQ_TWIDTH_MASK;
				`SPQ_OFF_BAUD: baud_q <= wb;
				`SPQ_OFF_CON0: con0_q <= wb & `SPQ_CON0_MASK;
				`SPQ_OFF_CON1: con1_q <= wb & `SPQ_CON1_MASK;
				`SPQ_OFF_CON2: con2_q <= wb & `SPQ_CON2_MASK;
				`SPQ_OFF_CLK: clk_q <= wb & `SPQ_CLK_MASK;
				`SPQ_OFF_EVT_EN: ev_en_q <= wb[`SPQ_EV_N-1:0];
				default: ;
				endcase
			end
			// the transfer counter steps down once per completed byte and holds at zero
			if (tc_zero || (byte_done && transfer_counter_q != 11'h000))
				transfer_counter_q <= transfer_counter_q - 11'h001;
			intf_q <= (wr_b0 && wa == `SPQ_OFF_INTF ?
				wb & `SPQ_INT_MASK : intf_q) | intf_set; // [R8]
			// status error bits clear by writing zero, set has priority
			tx_write_error_flag_q <= wr_err | (tx_write_error_flag_q & ~(w_stat & ~wb[`SPQ_ST_TX_WRITE_ERROR_FLAG])); // [R4]
			rx_read_error_flag_q <= rd_err | (rx_read_error_flag_q & ~(w_stat & ~wb[`SPQ_ST_RX_READ_ERROR_FLAG])); // [R2]
			ev_stat_q <= ev_set | (ev_stat_q &
				~({`SPQ_EV_N{w_evclr}} & wb[`SPQ_EV_N-1:0]));
		end
	end

	// level interrupt: any enabled event or flag holds it high
	assign irq = |(ev_stat_q & ev_en_q) | |(intf_q & inte_q);

	// read mux
	// the receive port pops on the ar edge, so its byte is latched then
	reg [7:0] rd_v;
	reg rd_hit;
	always @* begin
		rd_hit = 1'b1;
		rd_v = 8'h00;
		case (s_axi_araddr)
		`SPQ_OFF_INTF: rd_v = intf_q;
		`SPQ_OFF_INTE: rd_v = inte_q;
		`SPQ_OFF_TCNTH: rd_v = {5'h00, transfer_counter_q[10:8]}; // [R9]
		`SPQ_OFF_TCNTL: rd_v = transfer_counter_q[7:0]; // [R9]
		`SPQ_OFF_TWIDTH: rd_v = twidth_q;
		`SPQ_OFF_BAUD: rd_v = baud_q;
		`SPQ_OFF_CON0: rd_v = con0_q;
		`SPQ_OFF_CON1: rd_v = con1_q;
		`SPQ_OFF_CON2: rd_v = {spi_on & ss_act, 4'h0, con2_q[2:0]};
		`SPQ_OFF_STATUS: rd_v = {tx_write_error_flag_q, 1'b0, tx_empty, 1'b0,
			rx_read_error_flag_q, 2'b00, rx_full};
		`SPQ_OFF_RXB: rd_v = rx_empty ? 8'h00 : rxq[rx_rp_q[AW-1:0]]; // [R1]
		`SPQ_OFF_TXB: rd_v = 8'h00;
		`SPQ_OFF_CLK: rd_v = clk_q;
		`SPQ_OFF_EVT_STAT: rd_v = {5'h00, ev_stat_q};
		`SPQ_OFF_EVT_CLR: rd_v = 8'h00;
		`SPQ_OFF_EVT_EN: rd_v = {5'h00, ev_en_q};
		default: rd_hit = 1'b0;
		endcase
	end

	// axi channel state
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_q <= 8'h00;
			wd_q <= 32'h0;
			ws_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SPQ_AXI_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `SPQ_AXI_OKAY;
			s_axi_rdata <= 32'h0;
		end else begin
			// a write lands in the cycle both address and data are present
			if (wr_do) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wa <= `SPQ_OFF_EVT_EN && wa[1:0] == 2'b00) ?
					`SPQ_AXI_OKAY : `SPQ_AXI_SLVERR;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_have_q <= 1'b1;
					aw_q <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_have_q <= 1'b1;
					wd_q <= s_axi_wdata;
					ws_q <= s_axi_wstrb;
				end
				if (s_axi_bvalid && s_axi_bready)
					s_axi_bvalid <= 1'b0;
			end
			// the read answer is latched once and stands until rready
			if (rd_do) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h0, rd_v};
				s_axi_rresp <= rd_hit ? `SPQ_AXI_OKAY : `SPQ_AXI_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // spq_core

// [spq_core_props.sv]
// spq_core_props.sv: port checks of the spi buffer and clock select block.
// assumes it is bound to spq_core and sees only its ports.
module spq_core_props (
	input wire aclk, // clock
	input wire aresetn, // sync reset, low
	input wire [7:0] s_axi_awaddr, // aw
	input wire s_axi_awvalid, // aw
	input wire s_axi_awready, // aw
	input wire [31:0] s_axi_wdata, // w
	input wire [3:0] s_axi_wstrb, // w
	input wire s_axi_wvalid, // w
	input wire s_axi_wready, // w
	input wire [1:0] s_axi_bresp, // b
	input wire s_axi_bvalid, // b
	input wire s_axi_bready, // b
	input wire [7:0] s_axi_araddr, // ar
	input wire s_axi_arvalid, // ar
	input wire s_axi_arready, // ar
	input wire [31:0] s_axi_rdata, // r
	input wire [1:0] s_axi_rresp, // r
	input wire s_axi_rvalid, // r
	input wire s_axi_rready, // r
	input wire [8:0] clk_sources, // sources
	input wire sck_in, // pin
	input wire sdi_in, // pin
	input wire ss_n_in, // pin
	input wire sdo_out, // pin
	input wire spi_clk_sel, // picked source
	input wire irq // interrupt
);
	logic [3:0] sel_q, wv_q;
	logic [7:0] ra_q, wa_q;
	logic aw_h, w_h, wl_q;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// address and data may be taken in either order; the write commits
	// in the cycle in which both have been seen
	wire aw_in = aw_h || (s_axi_awvalid && s_axi_awready);
	wire w_in = w_h || (s_axi_wvalid && s_axi_wready);
	wire [7:0] w_a = aw_h ? wa_q : s_axi_awaddr;
	wire [3:0] w_v = w_h ? wv_q : s_axi_wdata[3:0];
	wire w_l = w_h ? wl_q : s_axi_wstrb[0];
	// shadow of the clock select field and of the last read address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_q <= 4'h0;
			ra_q <= 8'h00;
			{aw_h, w_h, wl_q} <= 3'b000;
			wa_q <= 8'h00;
			wv_q <= 4'h0;
		end else begin
			if (aw_in && w_in) begin
				{aw_h, w_h} <= 2'b00;
				if (w_l && w_a == 8'h30)
					sel_q <= w_v;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_h <= 1'b1;
					wa_q <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_h <= 1'b1;
					wv_q <= s_axi_wdata[3:0];
					wl_q <= s_axi_wstrb[0];
				end
			end
			if (s_axi_arvalid && s_axi_arready)
				ra_q <= s_axi_araddr;
		end
	end
	sequence wr_hs;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_hs;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_wr_answer: assert property (wr_hs |=> s_axi_bvalid)
		else $error("write got no response");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	a_rd_answer: assert property (rd_hs |=> s_axi_rvalid)
		else $error("read got no data");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	a_rx_byte: assert property (s_axi_rvalid && ra_q == 8'h28 |->
		s_axi_rdata[31:8] == 24'h0) else $error("rx read wider than byte");
	a_clk_mux: assert property (sel_q < 4'h9 |->
		spi_clk_sel == clk_sources[sel_q]) else $error("wrong clock source");
	a_clk_smt: assert property (sel_q == 4'h8 |->
		spi_clk_sel == clk_sources[8]) else $error("match source lost");
	a_clk_resv: assert property (sel_q > 4'h8 |-> !spi_clk_sel)
		else $error("reserved code picks a clock");
	a_flag_mask: assert property (s_axi_rvalid && ra_q[7:3] == 5'h0
		|-> s_axi_rdata[3] == 1'b0 && s_axi_rdata[0] == 1'b0)
		else $error("unimplemented flag bit set");
	a_cnt_high: assert property (s_axi_rvalid && ra_q == 8'h08 |->
		s_axi_rdata[7:3] == 5'h0) else $error("counter high too wide");
endmodule // spq_core_props
bind spq_core spq_core_props spq_core_props_i (.aclk, .aresetn,
	.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
	.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .clk_sources, .sck_in, .sdi_in, .ss_n_in, .sdo_out,
	.spi_clk_sel, .irq);

// [spq_map.vh]
// spq_map.vh: register offsets, field positions and reset values
// of the spi buffer, clock select and register block.
// assumes a 32-bit axi4-lite slave, one register per aligned word.
`ifndef SPQ_MAP_VH
`define SPQ_MAP_VH
// register byte addresses
`define SPQ_OFF_INTF 8'h00
`define SPQ_OFF_INTE 8'h04
`define SPQ_OFF_TCNTH 8'h08
`define SPQ_OFF_TCNTL 8'h0c
`define SPQ_OFF_TWIDTH 8'h10
`define SPQ_OFF_BAUD 8'h14
`define SPQ_OFF_CON0 8'h18
`define SPQ_OFF_CON1 8'h1c
`define SPQ_OFF_CON2 8'h20
`define SPQ_OFF_STATUS 8'h24
`define SPQ_OFF_RXB 8'h28
`define SPQ_OFF_TXB 8'h2c
`define SPQ_OFF_CLK 8'h30
`define SPQ_OFF_EVT_STAT 8'h34
`define SPQ_OFF_EVT_CLR 8'h38
`define SPQ_OFF_EVT_EN 8'h3c
// writable masks and reset values
`define SPQ_INT_MASK 8'hf6
`define SPQ_TWIDTH_MASK 8'h07
`define SPQ_CON0_MASK 8'h87
`define SPQ_CON1_MASK 8'hf7
`define SPQ_CON1_RST 8'h04
`define SPQ_CON2_MASK 8'h07
`define SPQ_CLK_MASK 8'h0f
`define SPQ_TCNTH_MASK 8'h07
// status bit positions
`define SPQ_ST_TX_WRITE_ERROR_FLAG 7
`define SPQ_ST_TXBE 5
`define SPQ_ST_RX_READ_ERROR_FLAG 3
`define SPQ_ST_CLRBF 2
`define SPQ_ST_RXBF 0
// interrupt flag positions
`define SPQ_IF_SRMT 7
`define SPQ_IF_TCZ 6
`define SPQ_IF_SOS 5
`define SPQ_IF_EOS 4
`define SPQ_IF_RXO 2
`define SPQ_IF_TXU 1
// con0 / con2 bit positions
`define SPQ_C0_EN 7
`define SPQ_C2_TXR 1
`define SPQ_C2_RXR 0
// clock source codes
`define SPQ_CS_SYS 4'h0
`define SPQ_CS_FAST 4'h1
`define SPQ_CS_MED 4'h2
`define SPQ_CS_REF 4'h3
`define SPQ_CS_TIMER_ZERO_OVERFLOW 4'h4
`define SPQ_CS_TMRA 4'h5
`define SPQ_CS_TMRB 4'h6
`define SPQ_CS_TMRC 4'h7
`define SPQ_CS_SMT 4'h8
// fifo depth, as pointer bits
`define SPQ_FIFO_AW 2
// event status bits: 0 rx read error, 1 tx write error, 2 byte received
`define SPQ_EV_N 3
`define SPQ_AXI_OKAY 2'b00
`define SPQ_AXI_SLVERR 2'b10
`endif

// [spq_peer.sv]
// spq_peer.sv: behavioural spi master facing the block's serial pins.
// assumes mode 0, msb first, select active low, 200 ns clock period.
module spq_peer (
	output logic sck, // serial clock, idle low
	output logic mosi, // data to the block
	output logic ss_n, // select, active low
	input wire miso // data from the block
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		sck = 1'b0;
		mosi = 1'b0;
		ss_n = 1'b1;
	end
	// one whole byte per frame; the clock stands still between frames
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		ss_n = 1'b0;
		#200;
		for (int i = 7; i >= 0; i--) begin
			mosi = tx[i];
			#100 sck = 1'b1;
			#99 rx[i] = miso; // late in the high phase: sync lag
			#1 sck = 1'b0;
		end
		#100 ss_n = 1'b1;
		mosi = ~mosi; // idle line must not look like held data
		#200; // select stays high between frames so the block sees the gap
	endtask
endmodule // spq_peer

// [tb_spq_core.sv]
// tb_spq_core.sv: register-level bench of the spi buffer block.
// assumes spq_core, spq_peer and the bound checker are compiled first.
module tb_spq_core;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr, s_axi_araddr, b;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, sck_in, sdi_in, ss_n_in;
	logic sdo_out, spi_clk_sel, irq;
	logic [8:0] clk_sources;
	int err_total = 0;
	int samples_checked = 0;
	always #12.5 aclk = ~aclk;
	spq_core spq_core_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clk_sources, .sck_in,
		.sdi_in, .ss_n_in, .sdo_out, .spi_clk_sel, .irq);
	spq_peer spq_peer_i (.sck(sck_in), .mosi(sdi_in), .ss_n(ss_n_in),
		.miso(sdo_out));
	task automatic tally_and_finish;
		$display("checked %0d mismatched %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tmo(input int n);
		if (n >= 60) begin
			chk("bus answer", 32'h1, 32'h0);
			tally_and_finish();
		end
	endtask
	// each channel is released at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 60);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		tmo(n);
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 60);
		v = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		tmo(n);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		rd(a);
		chk(nm, e, v);
	endtask
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, clk_sources} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
		{s_axi_arvalid, s_axi_rready} = 2'b00;
		s_axi_wstrb = 4'hf;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		// empty receive read, its event and the interrupt line
		wr(8'h3c, 32'h1);
		chk("write resp", 32'h0, {30'h0, r});
		rc(8'h28, 32'h0, "rx empty read");
		rc(8'h24, 32'h28, "status rx_read_error_flag");
		chk("irq raised", 32'h1, {31'h0, irq});
		wr(8'h38, 32'h1);
		chk("irq cleared", 32'h0, {31'h0, irq});
		wr(8'h24, 32'h0);
		rc(8'h24, 32'h20, "status cleared");
		rd(8'h40);
		chk("unmapped resp", 32'h2, {30'h0, r});
		wr(8'h40, 32'h0);
		chk("unmapped write", 32'h2, {30'h0, r});
		$display("test empty read done");
		// every clock select code, source high then low
		for (int c = 0; c < 16; c++) begin
			wr(8'h30, c);
			rc(8'h30, c, "clk select");
			clk_sources <= (c < 9) ? 9'h1 << c : 9'h1ff;
			repeat (2) @(posedge aclk);
			chk("clk picked", (c < 9), {31'h0, spi_clk_sel});
			clk_sources <= ~clk_sources;
			repeat (2) @(posedge aclk);
			chk("clk others", 32'h0, {31'h0, spi_clk_sel});
		end
		$display("test clock select done");
		// fill the transmit queue, overflow it, shift bytes both ways
		wr(8'h18, 32'h80);
		wr(8'h20, 32'h01);
		for (int i = 0; i < 4; i++)
			wr(8'h2c, 32'ha0 + i);
		rc(8'h24, 32'h00, "status tx full");
		wr(8'h2c, 32'h5a);
		rc(8'h24, 32'h80, "status tx_write_error_flag");
		for (int i = 0; i < 4; i++) begin
			spq_peer_i.xfer(8'hc0 + i, b);
			chk("byte out", 32'ha0 + i, {24'h0, b});
		end
		v = 32'h0;
		for (int k = 0; k < 40 && !v[0]; k++)
			rd(8'h24);
		chk("status rx full", 32'ha1, v);
		for (int i = 0; i < 4; i++)
			rc(8'h28, 32'hc0 + i, "rx byte");
		rc(8'h28, 32'h0, "rx after pops");
		rc(8'h24, 32'ha8, "status after pops");
		$display("test fifo done");
		// writable bits of the flag, enable and counter registers
		wr(8'h00, 32'hff);
		rc(8'h00, 32'hf6, "flag bits");
		wr(8'h04, 32'hff);
		rc(8'h04, 32'hf6, "enable bits");
		wr(8'h08, 32'hff);
		rc(8'h08, 32'h07, "count high");
		wr(8'h0c, 32'hff);
		rc(8'h0c, 32'hff, "count low");
		chk("flag irq", 32'h1, {31'h0, irq});
		$display("test registers done");
		tally_and_finish();
	end
endmodule // tb_spq_core
